// ==== core/ppm_pkg.sv ====
// Constants shared by the power management register block and its helpers.
// Assumes byte addresses of configuration space, eight bits wide.
package ppm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration space offsets.
    localparam logic [7:0]  PPM_OFF_PMCSR      = 8'h48;
    localparam logic [7:0]  PPM_OFF_EXT        = 8'h4A;
    localparam logic [7:0]  PPM_OFF_MISC       = 8'hF0;

    ////////////////////////////////////////////////////////////////////////////
    // Control and status register fields.
    localparam int          PPM_BIT_WAKE_FLAG  = 15;
    localparam int          PPM_BIT_WAKE_EN    = 8;
    localparam int          PPM_PS_MSB         = 1;
    localparam int          PPM_PS_LSB         = 0;
    localparam logic [15:0] PPM_PMCSR_RESET    = 16'h0000;
    localparam logic [15:0] PPM_PMCSR_RW_MASK  = 16'h8103;
    localparam logic [15:0] PPM_EXT_VALUE      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Power state encodings.
    typedef enum logic [1:0] {
        PPM_D0 = 2'b00,
        PPM_D1 = 2'b01,
        PPM_D2 = 2'b10,
        PPM_D3 = 2'b11
    } ppm_pstate_t;

    ////////////////////////////////////////////////////////////////////////////
    // Miscellaneous configuration register fields.
    localparam int          PPM_BIT_COLD_WAKE  = 15;
    localparam int          PPM_BIT_MID_WAKE   = 13;
    localparam int          PPM_BIT_MID_CAP    = 10;
    localparam logic [15:0] PPM_MISC_RW_MASK   = 16'hA43F;
    localparam logic [15:0] PPM_MISC_RESET     = 16'h2400;
    localparam logic [15:0] PPM_MISC_HI_VALUE  = 16'h0000;

endpackage

// ==== core/ppm_wake.sv ====
// Wake event flag, wake output enable and the open-drain wake pin drive.
// Assumes strobes from the same clock; untouched by the D3hot exit reset.
module ppm_wake
    import ppm_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic wake_event,
    input  wire logic flag_clr,
    input  wire logic en_wr,
    input  wire logic en_wdata,
    output logic      wake_event_flag_q,
    output logic      wake_output_enable_q,
    output logic      pme_oe_n_q
);

    ////////////////////////////////////////////////////////////////////////////
    // A new event wins over a simultaneous write-one clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_event_flag_q <= PPM_PMCSR_RESET[PPM_BIT_WAKE_FLAG];
        end else if (wake_event) begin
            wake_event_flag_q <= 1'b1;
        end else if (flag_clr) begin
            wake_event_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_output_enable_q <= PPM_PMCSR_RESET[PPM_BIT_WAKE_EN];
        end else if (en_wr) begin
            wake_output_enable_q <= en_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The pin is pulled low in the cycle after the flag and the enable are both set.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pme_oe_n_q <= 1'b1;
        end else begin
            pme_oe_n_q <= ~(wake_event_flag_q & wake_output_enable_q);
        end
    end

endmodule

// ==== core/ppm_misc.sv ====
// Miscellaneous configuration register, low half; the high half reads zero.
// Assumes a synchronous soft reset pulse from the D3hot exit logic.
module ppm_misc
    import ppm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        soft_rst,
    input  wire logic        wr_b0,
    input  wire logic        wr_b1,
    input  wire logic [15:0] wdata,
    output logic      [15:0] misc_q
);

    logic [15:0] misc_d;

    always_comb begin
        misc_d = misc_q;
        if (wr_b0) begin
            misc_d[7:0] = wdata[7:0] & PPM_MISC_RW_MASK[7:0];
        end
        if (wr_b1) begin
            misc_d[15:8] = wdata[15:8] & PPM_MISC_RW_MASK[15:8];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            misc_q <= PPM_MISC_RESET;
        end else if (soft_rst) begin
            misc_q <= PPM_MISC_RESET;
        end else begin
            misc_q <= misc_d;
        end
    end

endmodule

// ==== core/ppm_power_mgmt_regs.sv ====
// Power management register logic reached over configuration cycles.
// Assumes the configuration port and wake events come from the system clock domain.
//
// What this block does
// - Control/status contents survive the internal reset of a D3hot to D0 exit.
// - Wake event flag bit 15 sets on every wake event, enable or not.
// - Writing one clears the flag and releases the wake pin unless a wake event comes in the same cycle; zero does nothing.
// - Wake output enable bit 8 gates the wake pin; once it is cleared, the pin is released from the next cycle on.
// - Power state field bits 1:0 is writable; 00 D0, 01 D1, 10 D2, 11 D3.
// - Dynamic report control bits 14:9 read zero and ignore writes.
// - Dynamic report flag bit 4 reads zero and ignores writes.
// - Reserved bits 7:5 and 3:2 read zero and ignore writes.
// - Extension byte 15:8 reads 00h.
// - Bridge support byte 7:0 of the extension reads 00h.
// - Whole extension register reads zero and ignores writes.
// - Misc bit 15 is writable and drives the cold-state wake capability bit.
// - Misc bit 13 is writable and drives the D2 wake capability bit.
// - Misc bit 10 is writable and drives the Mid_state_cap_ctrl capability bit.
module ppm_power_mgmt_regs
    import ppm_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic        CFG_REQ,
    input  wire logic        CFG_WE,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [3:0]  CFG_BE,
    input  wire logic [31:0] CFG_WDATA,
    input  wire logic        WAKE_EVENT,
    output logic      [31:0] CFG_RDATA,
    output logic             CFG_ACK,
    output logic      [1:0]  POWER_STATE,
    output logic             D3HOT_EXIT_RST,
    output logic             PME_O,
    output logic             PME_OE_N,
    output logic             CAP_COLD_WAKE,
    output logic             CAP_MID_WAKE,
    output logic             CAP_MID_STATE
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and write strobes.
    logic        hit_pm;
    logic        hit_misc;
    logic        wr_pm_b0;
    logic        wr_pm_b1;
    logic        wr_misc_b0;
    logic        wr_misc_b1;
    logic        flag_clr;
    logic        d3_exit;
    logic [1:0]  power_state_field_q;
    logic        d3_exit_q;
    logic        wake_event_flag;
    logic        wake_output_enable;
    logic        pme_oe_n;
    logic [15:0] misc_q;
    logic [15:0] pmcsr_rd;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        ack_q;
    logic        pme_o_q;

    assign hit_pm     = CFG_ADDR[7:2] == PPM_OFF_PMCSR[7:2];
    assign hit_misc   = CFG_ADDR[7:2] == PPM_OFF_MISC[7:2];
    assign wr_pm_b0   = CFG_REQ & CFG_WE & hit_pm & CFG_BE[0];
    assign wr_pm_b1   = CFG_REQ & CFG_WE & hit_pm & CFG_BE[1];
    assign wr_misc_b0 = CFG_REQ & CFG_WE & hit_misc & CFG_BE[0];
    assign wr_misc_b1 = CFG_REQ & CFG_WE & hit_misc & CFG_BE[1];

    assign flag_clr   = wr_pm_b1 & CFG_WDATA[PPM_BIT_WAKE_FLAG];

    ////////////////////////////////////////////////////////////////////////////
    // Power state field and detection of the D3hot to D0 exit.
    // power state write
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            power_state_field_q <= PPM_PMCSR_RESET[PPM_PS_MSB:PPM_PS_LSB];
        end else if (wr_pm_b0) begin
            power_state_field_q <= CFG_WDATA[PPM_PS_MSB:PPM_PS_LSB];
        end
    end

    assign d3_exit = wr_pm_b0 && (power_state_field_q == PPM_D3)
                     && (CFG_WDATA[PPM_PS_MSB:PPM_PS_LSB] == PPM_D0);

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            d3_exit_q <= 1'b0;
        end else begin
            d3_exit_q <= d3_exit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake flag, enable and pin drive; this part sees only the system reset.
    // flag sets always
    ppm_wake u_wake (
        .clk                  (CLK_SYS),
        .rst                  (SYS_RST),
        .wake_event           (WAKE_EVENT),
        .flag_clr             (flag_clr),
        .en_wr                (wr_pm_b1),
        .en_wdata             (CFG_WDATA[PPM_BIT_WAKE_EN]),
        .wake_event_flag_q    (wake_event_flag),
        .wake_output_enable_q (wake_output_enable),
        .pme_oe_n_q           (pme_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Miscellaneous register; it does return to its defaults on the D3hot exit.
    // misc writable mask
    ppm_misc u_misc (
        .clk      (CLK_SYS),
        .rst      (SYS_RST),
        .soft_rst (d3_exit_q),
        .wr_b0    (wr_misc_b0),
        .wr_b1    (wr_misc_b1),
        .wdata    (CFG_WDATA[15:0]),
        .misc_q   (misc_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data; constant fields are built as zeros here.
    // zero fields
    always_comb begin
        pmcsr_rd = 16'h0000;
        pmcsr_rd[PPM_BIT_WAKE_FLAG] = wake_event_flag;
        pmcsr_rd[PPM_BIT_WAKE_EN] = wake_output_enable;
        pmcsr_rd[PPM_PS_MSB:PPM_PS_LSB] = power_state_field_q;
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_pm) begin
            rdata_d = {PPM_EXT_VALUE, pmcsr_rd};
        end else if (hit_misc) begin
            rdata_d = {PPM_MISC_HI_VALUE, misc_q};
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_q <= 32'h0000_0000;
        end else if (CFG_REQ && !CFG_WE) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= CFG_REQ;
        end
    end

    // The wake pin is open drain: its data value stays low, the enable steers it.
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            pme_o_q <= 1'b0;
        end else begin
            pme_o_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign CFG_RDATA      = rdata_q;
    assign CFG_ACK        = ack_q;
    assign POWER_STATE    = power_state_field_q;
    assign D3HOT_EXIT_RST = d3_exit_q;
    assign PME_O          = pme_o_q;
    assign PME_OE_N       = pme_oe_n;
    assign CAP_COLD_WAKE  = misc_q[PPM_BIT_COLD_WAKE];
    assign CAP_MID_WAKE   = misc_q[PPM_BIT_MID_WAKE];
    assign CAP_MID_STATE  = misc_q[PPM_BIT_MID_CAP];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic rd_pm_q;
    logic rd_misc_q;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_pm_q   <= 1'b0;
            rd_misc_q <= 1'b0;
        end else begin
            rd_pm_q   <= CFG_REQ & ~CFG_WE & hit_pm;
            rd_misc_q <= CFG_REQ & ~CFG_WE & hit_misc;
        end
    end

    default clocking ck @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    AST_SURVIVE_SOFT_RST: assert property (
        D3HOT_EXIT_RST && !(CFG_REQ && CFG_WE && hit_pm) |=>
            $stable(wake_output_enable) && $stable(POWER_STATE))
        else $error("control and status changed on the D3hot exit reset");

    AST_D3_EXIT_PULSE: assert property (
        d3_exit |=> D3HOT_EXIT_RST ##1 !D3HOT_EXIT_RST)
        else $error("D3hot exit reset pulse wrong");

    AST_FLAG_SETS: assert property (
        WAKE_EVENT |=> wake_event_flag)
        else $error("wake event did not set the flag");

    AST_FLAG_CLEARS: assert property (
        flag_clr && !WAKE_EVENT |=> !wake_event_flag ##1 PME_OE_N)
        else $error("write one did not clear flag and pin");

    AST_WRITE_ZERO_KEEPS: assert property (
        wr_pm_b1 && !CFG_WDATA[PPM_BIT_WAKE_FLAG] && wake_event_flag |=> wake_event_flag)
        else $error("write zero changed the flag");

    AST_ENABLE_GATES: assert property (
        !wake_output_enable |=> PME_OE_N)
        else $error("wake pin driven while disabled");

    AST_EVENT_DRIVES_PIN: assert property (
        WAKE_EVENT && wake_output_enable && !wr_pm_b1 |=> ##1 !PME_OE_N)
        else $error("enabled wake event did not drive the pin");

    AST_PIN_NEEDS_BOTH: assert property (
        !PME_OE_N |-> $past(wake_event_flag) && $past(wake_output_enable))
        else $error("wake pin driven without flag and enable");

    AST_POWER_STATE_WRITE: assert property (
        wr_pm_b0 |=> POWER_STATE == $past(CFG_WDATA[1:0]))
        else $error("power state field not written");

    AST_PMCSR_ZERO_FIELDS: assert property (
        CFG_ACK && rd_pm_q |-> (CFG_RDATA[15:0] & ~PPM_PMCSR_RW_MASK) == 16'h0000)
        else $error("read-only control and status bits not zero");

    AST_EXT_ZERO: assert property (
        CFG_ACK && rd_pm_q |-> CFG_RDATA[31:16] == PPM_EXT_VALUE)
        else $error("extension register not zero");

    AST_MISC_HI_ZERO: assert property (
        CFG_ACK && rd_misc_q |-> CFG_RDATA[31:16] == 16'h0000
            && (CFG_RDATA[15:0] & ~PPM_MISC_RW_MASK) == 16'h0000)
        else $error("misc read-only bits not zero");

    AST_MISC_CAPS: assert property (
        wr_misc_b1 && !d3_exit_q |=> CAP_COLD_WAKE == $past(CFG_WDATA[15])
            && CAP_MID_WAKE == $past(CFG_WDATA[13]) && CAP_MID_STATE == $past(CFG_WDATA[10]))
        else $error("capability bits do not follow misc register");

    AST_ACK_ONE_CYCLE: assert property (
        CFG_REQ |=> CFG_ACK)
        else $error("configuration access not acknowledged");

    AST_SET_WINS_CLEAR: assert property (
        WAKE_EVENT && flag_clr |=> wake_event_flag)
        else $error("clear beat a simultaneous wake event");

    AST_FLAG_KEPT_ON_EXIT: assert property (
        D3HOT_EXIT_RST && !WAKE_EVENT && !flag_clr |=> $stable(wake_event_flag))
        else $error("wake flag changed on the D3hot exit reset");

    AST_EXIT_ONLY_FROM_D3: assert property (
        D3HOT_EXIT_RST |-> $past(POWER_STATE) == PPM_D3 && POWER_STATE == PPM_D0)
        else $error("D3hot exit reset without a D3 to D0 write");

    AST_ENABLE_WRITE: assert property (
        wr_pm_b1 |=> wake_output_enable == $past(CFG_WDATA[PPM_BIT_WAKE_EN]))
        else $error("wake output enable not written");

    AST_STATE_HOLDS: assert property (
        !wr_pm_b0 |=> $stable(POWER_STATE))
        else $error("power state changed without a write");

    AST_READ_STATE: assert property (
        CFG_ACK && rd_pm_q |-> CFG_RDATA[PPM_PS_MSB:PPM_PS_LSB] == $past(POWER_STATE))
        else $error("power state read back wrong");

    AST_READ_FLAG_EN: assert property (
        CFG_ACK && rd_pm_q |-> CFG_RDATA[PPM_BIT_WAKE_FLAG] == $past(wake_event_flag)
            && CFG_RDATA[PPM_BIT_WAKE_EN] == $past(wake_output_enable))
        else $error("wake flag or enable read back wrong");

    AST_MISC_SOFT_RST: assert property (
        D3HOT_EXIT_RST |=> CAP_COLD_WAKE == PPM_MISC_RESET[PPM_BIT_COLD_WAKE]
            && CAP_MID_WAKE == PPM_MISC_RESET[PPM_BIT_MID_WAKE]
            && CAP_MID_STATE == PPM_MISC_RESET[PPM_BIT_MID_CAP])
        else $error("misc register not back at its defaults after the exit reset");

    AST_MISC_LOW_WRITE: assert property (
        wr_misc_b0 && !d3_exit_q |=> misc_q[7:0] == ($past(CFG_WDATA[7:0]) & PPM_MISC_RW_MASK[7:0]))
        else $error("misc low byte not written through its mask");

    AST_MISC_HOLDS: assert property (
        !wr_misc_b0 && !wr_misc_b1 && !d3_exit_q |=> $stable(misc_q))
        else $error("misc register changed without a write");

    AST_MISC_READ: assert property (
        CFG_ACK && rd_misc_q |-> CFG_RDATA[15:0] == $past(misc_q))
        else $error("misc register read back wrong");

endmodule

// ==== dv/ppm_host_model.sv ====
// Host bridge model that issues configuration reads and writes to the block.
// Assumes the block acknowledges each one-cycle request on the next cycle.
module ppm_host_model (
    input  wire logic        clk,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata,
    output logic             cfg_req,
    output logic             cfg_we,
    output logic      [7:0]  cfg_addr,
    output logic      [3:0]  cfg_be,
    output logic      [31:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cfg_req   = 1'b0;
        cfg_we    = 1'b0;
        cfg_addr  = 8'h00;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One access: request for one cycle, then take the answer in the ack cycle.
    task automatic access(input  logic        we_i,
                          input  logic [7:0]  addr_i,
                          input  logic [3:0]  be_i,
                          input  logic [31:0] wdata_i,
                          output logic [31:0] rdata_o,
                          output logic        ack_o);
        @(posedge clk);
        #1;
        cfg_req   = 1'b1;
        cfg_we    = we_i;
        cfg_addr  = addr_i;
        cfg_be    = be_i;
        cfg_wdata = wdata_i;
        @(posedge clk);
        #1;
        ack_o   = cfg_ack;
        rdata_o = cfg_rdata;
        cfg_req = 1'b0;
        cfg_we  = 1'b0;
        // Released lines show inverted values so stale qualifiers never look valid.
        cfg_addr  = ~cfg_addr;
        cfg_be    = ~cfg_be;
        cfg_wdata = ~cfg_wdata;
    endtask
endmodule

// ==== dv/ppm_power_mgmt_regs_tb.sv ====
// Self-checking bench for the power management register block.
// Assumes the host model drives the configuration port; the bench drives wake events.
module ppm_power_mgmt_regs_tb
    import ppm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys;
    logic        sys_rst;
    logic        cfg_req;
    logic        cfg_we;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata;
    logic        wake_event;
    logic [31:0] cfg_rdata;
    logic        cfg_ack;
    logic [1:0]  power_state;
    logic        d3hot_exit_rst;
    logic        pme_o;
    logic        pme_oe_n;
    logic        cap_cold_wake;
    logic        cap_mid_wake;
    logic        cap_mid_state;
    int          n_mismatch;
    int          check_count;
    int          cycle_count;

    ppm_power_mgmt_regs dut (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CFG_REQ(cfg_req), .CFG_WE(cfg_we), .CFG_ADDR(cfg_addr),
        .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata), .WAKE_EVENT(wake_event), .CFG_RDATA(cfg_rdata),
        .CFG_ACK(cfg_ack), .POWER_STATE(power_state), .D3HOT_EXIT_RST(d3hot_exit_rst), .PME_O(pme_o),
        .PME_OE_N(pme_oe_n), .CAP_COLD_WAKE(cap_cold_wake), .CAP_MID_WAKE(cap_mid_wake),
        .CAP_MID_STATE(cap_mid_state)
    );

    ppm_host_model host (
        .clk(clk_sys), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, timeout and verdict.
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    initial cycle_count = 0;
    always @(posedge clk_sys) begin
        cycle_count = cycle_count + 1;
        if (cycle_count == 2000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Compare tasks and access helpers.
    task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic exp, input logic got);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] rd;
        logic        ack;
        host.access(1'b1, a, be, d, rd, ack);
        chk_pin("write ack", 1'b1, ack);
    endtask

    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        ack;
        host.access(1'b0, a, 4'hF, 32'h00000000, rd, ack);
        chk_pin("read ack", 1'b1, ack);
        chk_data("read data", exp, rd);
    endtask

    task automatic pulse_wake();
        @(posedge clk_sys);
        #1 wake_event = 1'b1;
        @(posedge clk_sys);
        #1 wake_event = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic chk_caps(input logic cold, input logic mid_wake, input logic mid_cap);
        chk_pin("cap cold wake", cold, cap_cold_wake);
        chk_pin("cap mid wake", mid_wake, cap_mid_wake);
        chk_pin("cap mid state", mid_cap, cap_mid_state);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        n_mismatch  = 0;
        check_count = 0;
        sys_rst     = 1'b1;
        wake_event  = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        chk_pin("pme data", 1'b0, pme_o);
        chk_pin("pme enable n", 1'b1, pme_oe_n);
        chk_pin("exit pulse", 1'b0, d3hot_exit_rst);
        chk_caps(1'b0, 1'b1, 1'b1);
        cfg_rd(PPM_OFF_PMCSR, 32'h00000000);
        cfg_rd(PPM_OFF_EXT, 32'h00000000);
        cfg_rd(PPM_OFF_MISC, {16'h0000, PPM_MISC_RESET});
        for (int i = 0; i < 4; i++) begin
            cfg_wr(PPM_OFF_PMCSR, 4'h1, 32'(i));
            chk_data("power state", 32'(i), {30'h0, power_state});
            cfg_rd(PPM_OFF_PMCSR, 32'(i));
        end
        cfg_wr(PPM_OFF_PMCSR, 4'hF, 32'hFFFFFFFF);
        cfg_rd(PPM_OFF_PMCSR, 32'h00000103);
        chk_pin("pme enable n", 1'b1, pme_oe_n);
        pulse_wake();
        cfg_rd(PPM_OFF_PMCSR, 32'h00008103);
        chk_pin("pme enable n", 1'b0, pme_oe_n);
        cfg_wr(PPM_OFF_PMCSR, 4'h2, 32'h00000100);
        cfg_rd(PPM_OFF_PMCSR, 32'h00008103);
        cfg_wr(PPM_OFF_PMCSR, 4'h2, 32'h00008100);
        cfg_rd(PPM_OFF_PMCSR, 32'h00000103);
        chk_pin("pme enable n", 1'b1, pme_oe_n);
        cfg_wr(PPM_OFF_PMCSR, 4'h2, 32'h00000000);
        pulse_wake();
        cfg_rd(PPM_OFF_PMCSR, 32'h00008003);
        chk_pin("pme enable n", 1'b1, pme_oe_n);
        cfg_wr(PPM_OFF_PMCSR, 4'h2, 32'h00000100);
        cfg_rd(PPM_OFF_PMCSR, 32'h00008103);
        chk_pin("pme enable n", 1'b0, pme_oe_n);
        cfg_wr(PPM_OFF_MISC, 4'hF, 32'hFFFFFFFF);
        cfg_rd(PPM_OFF_MISC, {16'h0000, PPM_MISC_RW_MASK});
        chk_caps(1'b1, 1'b1, 1'b1);
        cfg_wr(PPM_OFF_MISC, 4'hF, 32'h00000000);
        cfg_rd(PPM_OFF_MISC, 32'h00000000);
        chk_caps(1'b0, 1'b0, 1'b0);
        cfg_wr(PPM_OFF_PMCSR, 4'h1, 32'h00000000);
        chk_pin("exit pulse", 1'b1, d3hot_exit_rst);
        chk_data("power state", 32'h0, {30'h0, power_state});
        cfg_rd(PPM_OFF_MISC, {16'h0000, PPM_MISC_RESET});
        chk_pin("exit pulse", 1'b0, d3hot_exit_rst);
        cfg_rd(PPM_OFF_PMCSR, 32'h00008100);
        chk_pin("pme enable n", 1'b0, pme_oe_n);
        chk_caps(1'b0, 1'b1, 1'b1);
        cfg_wr(8'h10, 4'hF, 32'hFFFFFFFF);
        cfg_rd(8'h10, 32'h00000000);
        wake_event = 1'b1;
        cfg_wr(PPM_OFF_PMCSR, 4'h2, 32'h00008100);
        wake_event = 1'b0;
        cfg_rd(PPM_OFF_PMCSR, 32'h00008100);
        cfg_wr(PPM_OFF_PMCSR, 4'h2, 32'h00008100);
        cfg_rd(PPM_OFF_PMCSR, 32'h00000100);
        chk_pin("pme enable n", 1'b1, pme_oe_n);
        chk_pin("pme data", 1'b0, pme_o);
        print_verdict();
    end
endmodule
